//--- logic/sscr_map.vh
// register offsets, field positions, reset values and timing counts for the supply/config bank
`ifndef SSCR_MAP_VH
`define SSCR_MAP_VH
`define SSCR_ADDR_STS 8'h03
`define SSCR_ADDR_MISC 8'h04
`define SSCR_ADDR_CHG 8'h05
`define SSCR_RST_STS 8'h00
`define SSCR_RST_MISC 8'h00
`define SSCR_RST_CHG 8'h15
`define SSCR_BIT_AOVR 7
`define SSCR_BIT_IOOVR 6
`define SSCR_BIT_BOFLAG 1
`define SSCR_BIT_BOWAKE 0
`define SSCR_BIT_IGNCLK 6
`define SSCR_BIT_BCAST 1
`define SSCR_PCHG_HI 7
`define SSCR_PCHG_LO 6
`define SSCR_POL_HI 5
`define SSCR_POL_LO 4
`define SSCR_KA_HI 3
`define SSCR_KA_LO 2
`define SSCR_POL_NOW 2'h0
`define SSCR_POL_TIMEOUT 2'h1
`define SSCR_POL_CLEAN 2'h2
// cycles at 50 MHz: ms times 50000
`define SSCR_CYC_PER_MS 50000
`define SSCR_KA_30 (30 * `SSCR_CYC_PER_MS)
`define SSCR_KA_25 (25 * `SSCR_CYC_PER_MS)
`define SSCR_KA_10 (10 * `SSCR_CYC_PER_MS)
`define SSCR_KA_5 (5 * `SSCR_CYC_PER_MS)
`define SSCR_CNT_W 21
// keepalive code points; the last code takes the shortest time
`define SSCR_KA_CODE_30 2'h0
`define SSCR_KA_CODE_25 2'h1
`define SSCR_KA_CODE_10 2'h2
// reset levels of single-bit state and outputs, of the precharge time and of the read data
`define SSCR_RST_LOW 1'h0
`define SSCR_RST_HIGH 1'h1
`define SSCR_RST_PCHG 2'h0
`define SSCR_RST_RDATA 8'h00
// read value of reserved status bits and of unmapped addresses
`define SSCR_STS_RSVD 4'h0
`define SSCR_RDATA_NONE 8'h00
`endif

//--- logic/sscr_regs.v
// supply status, misc control and charge/shutdown config register bank
`timescale 1ns/10ps
`include "sscr_map.vh"

// Notes on behaviour
// - analog override flag set when analog supply above 2V forces mode 0
// - io override flag set when io supply above 2V forces mode 0
// - brownout flag reads 1 after a brownout shutdown, else 0
// - writable brownout wake select: 0 stay asleep, 1 leave sleep
// - clock error shuts down unless ignore bit set
// - broadcast enable answers fixed address with pin bits as zero
// - precharge time code selects 2.5, 12.5, 25 or 50 ms
// - power down policy: immediate, keepalive timeout, or clean shutdown
// - keepalive time code selects 30, 25, 10 or 5 ms
// - wake control 0 sleeps the device, 1 wakes it
// - analog select 1 feeds regulator directly, 0 uses internal regulator
// - io select 0 allows all io supplies, 1 only low ones
module sscr_regs #(
  parameter KA_30 = `SSCR_KA_30,
  parameter KA_25 = `SSCR_KA_25,
  parameter KA_10 = `SSCR_KA_10,
  parameter KA_5 = `SSCR_KA_5
) (
  // clock and reset
  input wire sys_clk,
  input wire srst,
  // register port from control interface
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // supply and mode inputs
  input wire analog_supply_above_2v,
  input wire io_supply_above_2v,
  input wire analog_supply_select,
  input wire io_supply_select,
  input wire wake_control,
  input wire brownout_event,
  input wire clock_error,
  input wire io_supply_lost,
  input wire clean_shutdown_done,
  // control outputs
  output reg analog_supply_select_eff,
  output reg io_supply_select_eff,
  output reg sleep_active,
  output reg clock_error_shutdown,
  output reg broadcast_addressing_enable,
  output reg [1:0] input_cap_precharge_time,
  output reg digital_regulator_on
);

  // register storage
  reg brownout_wake_select;
  reg brownout_shutdown_flag;
  reg [7:0] misc_control;
  reg [7:0] charge_shutdown_config;
  // keepalive timer state
  reg [`SSCR_CNT_W-1:0] ka_count;
  reg [`SSCR_CNT_W-1:0] next_ka_count;
  reg [`SSCR_CNT_W-1:0] ka_limit;
  reg next_reg_on;
  // read path
  reg [7:0] next_rdata;
  // decoded fields and live status
  wire [1:0] power_down_policy;
  wire [1:0] regulator_keepalive_time;
  wire analog_supply_override_flag;
  wire io_supply_override_flag;
  wire ka_expired;
  // write strobes, one per register
  wire wr_status;
  wire wr_misc;
  wire wr_charge;
  // next values of the control outputs
  wire next_analog_eff;
  wire next_io_eff;
  wire next_sleep;
  wire next_clk_shutdown;

  // write decode; unmapped addresses hit none of these and are dropped
  assign wr_status = reg_wr & (reg_addr == `SSCR_ADDR_STS);
  assign wr_misc = reg_wr & (reg_addr == `SSCR_ADDR_MISC);
  assign wr_charge = reg_wr & (reg_addr == `SSCR_ADDR_CHG);

  // field views of the charge/shutdown register
  assign power_down_policy = charge_shutdown_config[`SSCR_POL_HI:`SSCR_POL_LO];
  assign regulator_keepalive_time = charge_shutdown_config[`SSCR_KA_HI:`SSCR_KA_LO];

  // override flags are live, so they follow the supply without any write
  assign analog_supply_override_flag = analog_supply_above_2v & analog_supply_select;
  assign io_supply_override_flag = io_supply_above_2v & io_supply_select;

  // status register: only the wake select bit takes a write
  always @(posedge sys_clk) begin
    if (srst) begin
      brownout_wake_select <= `SSCR_RST_LOW;
    end else if (wr_status) begin
      brownout_wake_select <= reg_wdata[`SSCR_BIT_BOWAKE];
    end
  end

  // misc control; reserved bits kept as written so readback matches
  always @(posedge sys_clk) begin
    if (srst) begin
      misc_control <= `SSCR_RST_MISC;
    end else if (wr_misc) begin
      misc_control <= reg_wdata;
    end
  end

  // charge/shutdown config; host is trusted to keep reserved bits at reset value
  always @(posedge sys_clk) begin
    if (srst) begin
      charge_shutdown_config <= `SSCR_RST_CHG;
    end else if (wr_charge) begin
      charge_shutdown_config <= reg_wdata;
    end
  end

  // brownout flag is sticky until reset; no host write can clear it
  always @(posedge sys_clk) begin
    if (srst) begin
      brownout_shutdown_flag <= `SSCR_RST_LOW;
    end else if (brownout_event) begin
      brownout_shutdown_flag <= `SSCR_RST_HIGH;
    end
  end

  // keepalive limit from code; counts are parameters so a bench can shorten them
  always @* begin
    case (regulator_keepalive_time)
      `SSCR_KA_CODE_30: ka_limit = KA_30[`SSCR_CNT_W-1:0];
      `SSCR_KA_CODE_25: ka_limit = KA_25[`SSCR_CNT_W-1:0];
      `SSCR_KA_CODE_10: ka_limit = KA_10[`SSCR_CNT_W-1:0];
      default: ka_limit = KA_5[`SSCR_CNT_W-1:0];
    endcase
  end

  // keepalive has run out once the count reaches the limit
  assign ka_expired = (ka_count >= ka_limit);

  // keepalive counter runs only under the timeout policy while the supply is lost;
  // it parks at the limit so a wrap can never switch the regulator back on
  always @* begin
    next_ka_count = {`SSCR_CNT_W{1'h0}};
    if (io_supply_lost && (power_down_policy == `SSCR_POL_TIMEOUT)) begin
      if (ka_expired) begin
        next_ka_count = ka_count;
      end else begin
        next_ka_count = ka_count + {{(`SSCR_CNT_W-1){1'h0}}, 1'h1};
      end
    end
  end

  // regulator enable per power-down policy; a present supply keeps it on
  always @* begin
    next_reg_on = `SSCR_RST_HIGH;
    if (io_supply_lost) begin
      case (power_down_policy)
        `SSCR_POL_NOW: next_reg_on = `SSCR_RST_LOW;
        `SSCR_POL_TIMEOUT: next_reg_on = ~ka_expired;
        `SSCR_POL_CLEAN: next_reg_on = ~clean_shutdown_done;
        default: next_reg_on = `SSCR_RST_LOW; // reserved code: immediate off is safest
      endcase
    end
  end

  // read mux; reserved status bits read as their reset value
  always @* begin
    case (reg_addr)
      `SSCR_ADDR_STS: begin
        next_rdata = {analog_supply_override_flag, io_supply_override_flag,
          `SSCR_STS_RSVD, brownout_shutdown_flag, brownout_wake_select};
      end
      `SSCR_ADDR_MISC: next_rdata = misc_control;
      `SSCR_ADDR_CHG: next_rdata = charge_shutdown_config;
      default: next_rdata = `SSCR_RDATA_NONE;
    endcase
  end

  // read data registered: it answers the address seen at the previous edge
  always @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= `SSCR_RST_RDATA;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // keepalive counter and regulator enable; regulator stays on through reset
  always @(posedge sys_clk) begin
    if (srst) begin
      ka_count <= {`SSCR_CNT_W{1'h0}};
      digital_regulator_on <= `SSCR_RST_HIGH;
    end else begin
      ka_count <= next_ka_count;
      digital_regulator_on <= next_reg_on;
    end
  end

  // effective supply modes: a supply above 2V forces the mode to 0
  assign next_analog_eff = analog_supply_select & ~analog_supply_above_2v;
  assign next_io_eff = io_supply_select & ~io_supply_above_2v;

  // after a brownout, waking needs the wake select as well as wake control
  assign next_sleep = brownout_shutdown_flag ? ~(brownout_wake_select & wake_control)
    : ~wake_control;

  // clock error shuts down unless the ignore bit is set
  assign next_clk_shutdown = clock_error & ~misc_control[`SSCR_BIT_IGNCLK];

  // supply mode outputs
  always @(posedge sys_clk) begin
    if (srst) begin
      analog_supply_select_eff <= `SSCR_RST_LOW;
      io_supply_select_eff <= `SSCR_RST_LOW;
    end else begin
      analog_supply_select_eff <= next_analog_eff;
      io_supply_select_eff <= next_io_eff;
    end
  end

  // sleep output; reset leaves the device asleep until wake control says otherwise
  always @(posedge sys_clk) begin
    if (srst) begin
      sleep_active <= `SSCR_RST_HIGH;
    end else begin
      sleep_active <= next_sleep;
    end
  end

  // clock error response, registered so the output comes from a flop
  always @(posedge sys_clk) begin
    if (srst) begin
      clock_error_shutdown <= `SSCR_RST_LOW;
    end else begin
      clock_error_shutdown <= next_clk_shutdown;
    end
  end

  // config field outputs trail a register write by two cycles, one behind the register
  always @(posedge sys_clk) begin
    if (srst) begin
      broadcast_addressing_enable <= `SSCR_RST_LOW;
      input_cap_precharge_time <= `SSCR_RST_PCHG;
    end else begin
      broadcast_addressing_enable <= misc_control[`SSCR_BIT_BCAST];
      input_cap_precharge_time <= charge_shutdown_config[`SSCR_PCHG_HI:`SSCR_PCHG_LO];
    end
  end

endmodule

//--- tb/sscr_assertions.sv
// port assertions for the supply/config register bank
`timescale 1ns/10ps
module sscr_assertions (
  // clock, reset and register port
  input wire sys_clk,
  input wire srst,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  // status inputs and control outputs
  input wire clock_error,
  input wire brownout_event,
  input wire wake_control,
  input wire clock_error_shutdown,
  input wire broadcast_addressing_enable,
  input wire [1:0] input_cap_precharge_time,
  input wire sleep_active,
  // supply levels, policy input and the outputs they steer
  input wire analog_supply_above_2v,
  input wire io_supply_above_2v,
  input wire io_supply_lost,
  input wire analog_supply_select_eff,
  input wire io_supply_select_eff,
  input wire digital_regulator_on
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  property p_ce; !clock_error |=> !clock_error_shutdown; endproperty
  a_ce: assert property (p_ce) else $error("shutdown without clock error");
  property p_bc; reg_wr && reg_addr == 8'h04 |->
    ##2 broadcast_addressing_enable == $past(reg_wdata[1], 2); endproperty
  a_bc: assert property (p_bc) else $error("broadcast enable wrong");
  property p_pc; reg_wr && reg_addr == 8'h05 |->
    ##2 input_cap_precharge_time == $past(reg_wdata[7:6], 2); endproperty
  a_pc: assert property (p_pc) else $error("precharge time wrong");
  property p_rs; reg_addr == 8'h03 |=> reg_rdata[5:2] == 4'h0; endproperty
  a_rs: assert property (p_rs) else $error("reserved status bits set");
  property p_bo; brownout_event ##1 reg_addr == 8'h03 |=> reg_rdata[1]; endproperty
  a_bo: assert property (p_bo) else $error("brownout flag missing");
  property p_sl; !wake_control |=> sleep_active; endproperty
  a_sl: assert property (p_sl) else $error("awake with wake control low");
  property p_wk; reg_wr && reg_addr == 8'h03 ##1 reg_addr == 8'h03 |=>
    reg_rdata[0] == $past(reg_wdata[0], 2); endproperty
  a_wk: assert property (p_wk) else $error("wake select readback wrong");
  property p_kt; reg_wr && reg_addr == 8'h05 ##1 reg_addr == 8'h05 |=>
    reg_rdata[5:2] == $past(reg_wdata[5:2], 2); endproperty
  a_kt: assert property (p_kt) else $error("policy or keepalive readback wrong");
  property p_ae; analog_supply_above_2v |=> !analog_supply_select_eff; endproperty
  a_ae: assert property (p_ae) else $error("analog mode not forced off");
  property p_ie; io_supply_above_2v |=> !io_supply_select_eff; endproperty
  a_ie: assert property (p_ie) else $error("io mode not forced off");
  property p_dr; !io_supply_lost |=> digital_regulator_on; endproperty
  a_dr: assert property (p_dr) else $error("regulator off with io supply present");
endmodule
bind sscr_regs sscr_assertions u_chk (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .clock_error(clock_error),
  .brownout_event(brownout_event), .wake_control(wake_control), .sleep_active(sleep_active),
  .clock_error_shutdown(clock_error_shutdown),
  .broadcast_addressing_enable(broadcast_addressing_enable),
  .input_cap_precharge_time(input_cap_precharge_time),
  .analog_supply_above_2v(analog_supply_above_2v), .io_supply_above_2v(io_supply_above_2v),
  .io_supply_lost(io_supply_lost), .analog_supply_select_eff(analog_supply_select_eff),
  .io_supply_select_eff(io_supply_select_eff), .digital_regulator_on(digital_regulator_on));

//--- tb/sscr_host.sv
// host model driving the register port
`timescale 1ns/10ps
module sscr_host (
  // register port
  input wire sys_clk,
  output reg [7:0] reg_addr = 8'h00,
  output reg reg_wr = 1'b0,
  output reg [7:0] reg_wdata = 8'h00,
  input wire [7:0] reg_rdata
);
  // reserved status and charge/shutdown config fields carry reset values; data line scrambled once released
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge sys_clk) #1;
      reg_addr = a;
      reg_wdata = (a == 8'h03) ? (v & 8'hC3) : (a == 8'h05) ? {v[7:2], 2'h1} : v;
      reg_wr = 1'b1;
      @(posedge sys_clk) #1;
      reg_wr = 1'b0;
      reg_wdata = ~reg_wdata;
    end
  endtask
  // read data is registered, so hold the address across two edges
  task rd(input [7:0] a, output [7:0] v);
    begin
      @(posedge sys_clk) #1;
      reg_addr = a;
      repeat (2) @(posedge sys_clk);
      #1 v = reg_rdata;
    end
  endtask
endmodule

//--- tb/tb_top.sv
// self-checking bench for the supply/config register bank
`timescale 1ns/10ps
`define CHK(s, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %s exp %h got %h", s, e, g); end end
module tb_top;
  reg sys_clk = 1'b0;
  reg srst = 1'b1;
  reg ab = 1'b0, ib = 1'b0, wake = 1'b0, bo = 1'b0, ce = 1'b0, lost = 1'b0;
  reg asel = 1'b1, isel = 1'b1, clean = 1'b0;
  wire [7:0] ra, wd, rdat;
  wire [1:0] pct;
  wire wr, aeff, ieff, slp, ces, bce, digital_regulator;
  reg [7:0] d;
  reg [25:0] rows [0:4];
  integer num_errors = 0, n_checks = 0, i, n;
  always #10 sys_clk = ~sys_clk;
  sscr_host host (.sys_clk(sys_clk), .reg_addr(ra), .reg_wr(wr), .reg_wdata(wd), .reg_rdata(rdat));
  // short keepalive counts keep the run brief
  sscr_regs #(.KA_30(30), .KA_25(25), .KA_10(10), .KA_5(5)) DUT (.sys_clk(sys_clk), .srst(srst),
    .reg_addr(ra), .reg_wr(wr), .reg_wdata(wd), .reg_rdata(rdat), .analog_supply_above_2v(ab),
    .io_supply_above_2v(ib), .analog_supply_select(asel), .io_supply_select(isel),
    .wake_control(wake), .brownout_event(bo), .clock_error(ce), .io_supply_lost(lost),
    .clean_shutdown_done(clean), .analog_supply_select_eff(aeff), .io_supply_select_eff(ieff),
    .sleep_active(slp), .clock_error_shutdown(ces), .broadcast_addressing_enable(bce),
    .input_cap_precharge_time(pct), .digital_regulator_on(digital_regulator));
  task print_verdict;
    begin
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  // rows: supply-above bits, address, write data, expected readback
  initial begin
    rows[0] = 26'h303FFC1;
    rows[1] = 26'h0044242;
    rows[2] = 26'h205FFFD;
    rows[3] = 26'h107FF00;
    rows[4] = 26'h0051D1D;
    repeat (20) @(posedge sys_clk);
    #1 srst = 1'b0;
    for (i = 0; i < 5; i++) begin
      {ab, ib} = rows[i][25:24];
      host.wr(rows[i][23:16], rows[i][15:8]);
      host.rd(rows[i][23:16], d);
      `CHK("readback", rows[i][7:0], d)
      `CHK("analog_eff", ~ab, aeff)
      `CHK("io_eff", ~ib, ieff)
    end
    `CHK("broadcast", 1'b1, bce)
    host.wr(8'h05, 8'h9D);
    repeat (2) @(posedge sys_clk);
    #1 `CHK("precharge", 2'h2, pct)
    // supplies high but modes not selected: nothing was forced, no flag
    {asel, isel, ab, ib} = 4'h3;
    host.rd(8'h03, d);
    `CHK("analog_flag_unselected", 1'b0, d[7])
    `CHK("io_flag_unselected", 1'b0, d[6])
    {asel, isel} = 2'h3;
    ce = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 `CHK("ignored_clk_err", 1'b0, ces)
    host.wr(8'h04, 8'h00);
    repeat (2) @(posedge sys_clk);
    #1 `CHK("clk_err_shutdown", 1'b1, ces)
    bo = 1'b1;
    wake = 1'b1;
    host.rd(8'h03, d);
    bo = 1'b0;
    `CHK("brownout_flag", 1'b1, d[1])
    `CHK("wake_after_brownout", 1'b0, slp)
    host.wr(8'h03, 8'h00);
    repeat (2) @(posedge sys_clk);
    #1 `CHK("stay_asleep", 1'b1, slp)
    // policy 1 with the shortest keepalive code, bounded wait for the drop
    lost = 1'b1;
    for (n = 0; n < 50 && digital_regulator === 1'b1; n++) @(posedge sys_clk) #1;
    `CHK("keepalive", 1'b1, n >= 5 && n <= 8)
    // clean-shutdown policy holds the regulator until shutdown completes
    host.wr(8'h05, 8'h2D);
    repeat (2) @(posedge sys_clk);
    #1 `CHK("clean_wait", 1'b1, digital_regulator)
    clean = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 `CHK("clean_done_off", 1'b0, digital_regulator)
    clean = 1'b0;
    host.wr(8'h05, 8'h0D);
    repeat (2) @(posedge sys_clk);
    #1 `CHK("immediate_off", 1'b0, digital_regulator)
    srst = 1'b1;
    @(posedge sys_clk) #1;
    srst = 1'b0;
    host.rd(8'h05, d);
    `CHK("reset_cfg", 8'h15, d)
    host.rd(8'h04, d);
    `CHK("reset_misc", 8'h00, d)
    print_verdict;
  end
endmodule
